// file: rtl/tss_regs.vh
// Register map, field positions, codes and reset values of the target select sequencer.
// Assumes a 4-bit byte-wide register port; included by the sequencer module only.
`ifndef TSS_REGS_VH
`define TSS_REGS_VH

// Register offsets
`define TSS_OFF_CTRL        4'h0
`define TSS_OFF_IRQ_STATUS  4'h1
`define TSS_OFF_IRQ_MASK    4'h2
`define TSS_OFF_GROUP       4'h3
`define TSS_OFF_CAUSE       4'h5
`define TSS_OFF_STEP        4'h6

// Control register fields
`define TSS_CTRL_EXT_MSG    0
`define TSS_CTRL_ENABLE     1
`define TSS_CTRL_RESET      8'h00

// Interrupt status and mask bits
`define TSS_IRQ_DONE        0
`define TSS_IRQ_PARITY      1
`define TSS_IRQ_ATN_HALT    2
`define TSS_IRQ_WIDTH       3
`define TSS_MASK_RESET      3'h0

// Interrupt cause codes
`define TSS_CAUSE_SEL       8'h01
`define TSS_CAUSE_SEL_ATN   8'h02
`define TSS_CAUSE_SVC       8'h10
`define TSS_CAUSE_NONE      8'h00

// Sequence step values
`define TSS_STEP_ID         3'h0
`define TSS_STEP_CMD        3'h1
`define TSS_STEP_DONE       3'h2
`define TSS_STEP_EXT_MSG    3'h4
`define TSS_STEP_EXT_CMD    3'h5
`define TSS_STEP_EXT_DONE   3'h6

// Message and command block constants
`define TSS_NULL_MSG        8'h00
`define TSS_IDENTIFY_BIT    7
`define TSS_EXT_MSG_COUNT   2'h3
`define TSS_LEN_GRP0        4'h6
`define TSS_LEN_GRP1        4'ha
`define TSS_LEN_GRP5        4'hc

`endif

// file: rtl/tss_sequencer.v
// Target-side selection sequencer: captures bus ID, message bytes and command block.
// Assumes a bus-phase layer on clk_in that delivers one byte per pulse with parity status;
// only the ATN pin arrives asynchronously and is synchronised here.
`timescale 1ns/100ps
`include "tss_regs.vh"

// What this block does
// - Selected without ATN, full command block and ATN raised in command phase reports step 2, cause 11 hex.
// - Selected without ATN, a command parity error with ATN held stops early with step 1, cause 11 hex.
// - Selected without ATN, full command block with no ATN reports step 2, cause 01 hex and group valid for groups 0, 1, 2 and 5.
// - Selected without ATN, a command parity error without ATN stops with step 1, cause 01 hex, partial block kept.
// - Selection without ATN first places the bus ID in the FIFO at step 0, then a null message byte as step 1 begins.
// - Extended messages off, ATN selection with one message byte and full block under ATN reports step 2, cause 12 hex.
// - ATN selection with a command parity error under ATN halts with cause 12 hex, step 1 or step 5 if extended.
// - Extended messages off, ATN still held after the first message byte stores ID and byte, halts at step 0, cause 12 hex.
// - Extended messages off, ATN selection with one message byte and full block without ATN reports step 2, cause 02 hex.
// - Extended messages off, a command parity error without ATN halts with step 1, cause 02 hex.
// - Extended messages on, ATN still held after the third message byte halts with step 4, cause 12 hex.
// - Extended messages on, three message bytes and the full block without ATN report step 6, cause 02 hex.
// - Extended messages on, a command parity error without ATN halts with step 5, cause 02 hex.
module tss_sequencer #(
  parameter DATA_W = 8
) (
  input  wire              clk_in,
  input  wire              rst_n_in,
  input  wire [3:0]        addr_in,
  input  wire [7:0]        wdata_in,
  input  wire              wr_in,
  input  wire              rd_in,
  output reg  [7:0]        rdata_out,
  input  wire              sel_in,
  input  wire              sel_atn_in,
  input  wire [DATA_W-1:0] bus_id_in,
  input  wire              atn_pin_in,
  input  wire              byte_valid_in,
  input  wire [DATA_W-1:0] byte_in,
  input  wire              parity_err_in,
  output reg               fifo_wr_out,
  output reg  [DATA_W-1:0] fifo_data_out,
  output reg  [1:0]        phase_out,
  output reg               busy_out,
  output reg               irq_out
);

  // Sequencer states
  localparam ST_IDLE = 3'h0;
  localparam ST_NULL = 3'h1;
  localparam ST_MSG  = 3'h2;
  localparam ST_CMD  = 3'h3;
  localparam ST_HOLD = 3'h4;

  // Bus phases shown to the bus-phase layer
  localparam PH_NONE = 2'h0;
  localparam PH_MSG  = 2'h1;
  localparam PH_CMD  = 2'h2;

  // Command block length for a group code; unknown groups fall back to six bytes
  function [4:0] grp_len;
    input [2:0] grp;
    begin
      case (grp)
        3'h0:    grp_len = {1'b1, `TSS_LEN_GRP0};
        3'h1:    grp_len = {1'b1, `TSS_LEN_GRP1};
        3'h2:    grp_len = {1'b1, `TSS_LEN_GRP1};
        3'h5:    grp_len = {1'b1, `TSS_LEN_GRP5};
        default: grp_len = {1'b0, `TSS_LEN_GRP0};
      endcase
    end
  endfunction

  reg [2:0]        state;
  reg [7:0]        ctrl;
  reg [2:0]        irq_status;
  reg [2:0]        irq_mask;
  reg [7:0]        cause;
  reg [2:0]        step;
  reg [2:0]        group;
  reg              group_valid;
  reg [3:0]        cmd_len;
  reg [3:0]        cmd_cnt;
  reg [1:0]        msg_cnt;
  reg              atn_sel;
  reg              atn_s1;
  reg              atn_s2;

  reg [2:0]        next_state;
  reg [7:0]        next_cause;
  reg [2:0]        next_step;
  reg [2:0]        next_group;
  reg              next_group_valid;
  reg [3:0]        next_cmd_len;
  reg [3:0]        next_cmd_cnt;
  reg [1:0]        next_msg_cnt;
  reg              next_atn_sel;
  reg              next_fifo_wr;
  reg [DATA_W-1:0] next_fifo_data;
  reg [2:0]        ev_set;
  reg [2:0]        next_irq_status;
  reg [4:0]        len_info;

  wire ext_msg   = ctrl[`TSS_CTRL_EXT_MSG];
  wire enabled   = ctrl[`TSS_CTRL_ENABLE];
  wire cause_rd  = rd_in && (addr_in == `TSS_OFF_CAUSE);
  wire sel_base  = atn_sel ? 1'b1 : 1'b0;
  wire [7:0] base_cause = sel_base ? `TSS_CAUSE_SEL_ATN : `TSS_CAUSE_SEL;
  wire [7:0] svc_cause  = atn_s2 ? (base_cause | `TSS_CAUSE_SVC) : base_cause;

  // ATN comes straight from the cable, so it passes two flops before any decision
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      atn_s1 <= 1'b0;
      atn_s2 <= 1'b0;
    end else begin
      atn_s1 <= atn_pin_in;
      atn_s2 <= atn_s1;
    end
  end

  // Sequencer decisions; each halt parks in ST_HOLD so the step cannot move under the host
  always @* begin
    next_state       = state;
    next_cause       = cause;
    next_step        = step;
    next_group       = group;
    next_group_valid = group_valid;
    next_cmd_len     = cmd_len;
    next_cmd_cnt     = cmd_cnt;
    next_msg_cnt     = msg_cnt;
    next_atn_sel     = atn_sel;
    next_fifo_wr     = 1'b0;
    next_fifo_data   = fifo_data_out;
    ev_set           = 3'h0;
    len_info         = grp_len(byte_in[7:5]);
    case (state)
      ST_IDLE: begin
        if (sel_in && enabled) begin
          next_fifo_wr     = 1'b1;
          next_fifo_data   = bus_id_in;
          next_atn_sel     = sel_atn_in;
          next_step        = `TSS_STEP_ID;
          next_cause       = `TSS_CAUSE_NONE;
          next_group_valid = 1'b0;
          next_cmd_cnt     = 4'h0;
          next_msg_cnt     = 2'h0;
          next_state       = sel_atn_in ? ST_MSG : ST_NULL;
        end
      end
      ST_NULL: begin
        // No message phase without ATN, so a null message stands in for it
        next_fifo_wr   = 1'b1;
        next_fifo_data = `TSS_NULL_MSG;
        next_step      = `TSS_STEP_CMD;
        next_state     = ST_CMD;
      end
      ST_MSG: begin
        if (byte_valid_in) begin
          next_fifo_wr   = 1'b1;
          next_fifo_data = byte_in;
          next_msg_cnt   = msg_cnt + 2'h1;
          if (msg_cnt == 2'h0 && (parity_err_in || !byte_in[`TSS_IDENTIFY_BIT])) begin
            next_cause = `TSS_CAUSE_SEL_ATN;
            next_step  = `TSS_STEP_ID;
            ev_set     = 3'h1 << `TSS_IRQ_PARITY;
            next_state = ST_HOLD;
          end else if (!ext_msg) begin
            if (atn_s2) begin
              next_cause = `TSS_CAUSE_SEL_ATN | `TSS_CAUSE_SVC;
              next_step  = `TSS_STEP_ID;
              ev_set     = 3'h1 << `TSS_IRQ_ATN_HALT;
              next_state = ST_HOLD;
            end else begin
              next_step  = `TSS_STEP_CMD;
              next_state = ST_CMD;
            end
          end else if (next_msg_cnt == `TSS_EXT_MSG_COUNT) begin
            if (atn_s2) begin
              next_cause = `TSS_CAUSE_SEL_ATN | `TSS_CAUSE_SVC;
              next_step  = `TSS_STEP_EXT_MSG;
              ev_set     = 3'h1 << `TSS_IRQ_ATN_HALT;
              next_state = ST_HOLD;
            end else begin
              next_step  = `TSS_STEP_EXT_CMD;
              next_state = ST_CMD;
            end
          end else if (!atn_s2) begin
            // Initiator dropped ATN early: no queue tag follows, go to command
            next_step  = `TSS_STEP_EXT_CMD;
            next_state = ST_CMD;
          end
        end
      end
      ST_CMD: begin
        if (byte_valid_in) begin
          if (parity_err_in) begin
            // Bad byte is not stored; the FIFO keeps the partial block
            next_cause = svc_cause;
            ev_set     = 3'h1 << `TSS_IRQ_PARITY;
            next_state = ST_HOLD;
          end else begin
            next_fifo_wr   = 1'b1;
            next_fifo_data = byte_in;
            next_cmd_cnt   = cmd_cnt + 4'h1;
            if (cmd_cnt == 4'h0) begin
              next_group       = byte_in[7:5];
              next_group_valid = len_info[4];
              next_cmd_len     = len_info[3:0];
            end
            if (next_cmd_cnt == ((cmd_cnt == 4'h0) ? len_info[3:0] : cmd_len)) begin
              next_cause = svc_cause;
              next_step  = (step == `TSS_STEP_EXT_CMD) ? `TSS_STEP_EXT_DONE : `TSS_STEP_DONE;
              next_state = ST_HOLD;
            end
          end
        end
      end
      ST_HOLD: begin
        // Step and cause stay put until software has read the cause
        if (cause_rd) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    if (next_state == ST_HOLD && state != ST_HOLD) begin
      ev_set = ev_set | (3'h1 << `TSS_IRQ_DONE);
    end
    // Set wins over a write-one clear landing in the same cycle
    next_irq_status = irq_status;
    if (wr_in && addr_in == `TSS_OFF_IRQ_STATUS) begin
      next_irq_status = irq_status & ~wdata_in[2:0];
    end
    next_irq_status = next_irq_status | ev_set;
  end

  // Sequencer and capture registers
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state         <= ST_IDLE;
      cause         <= `TSS_CAUSE_NONE;
      step          <= `TSS_STEP_ID;
      group         <= 3'h0;
      group_valid   <= 1'b0;
      cmd_len       <= `TSS_LEN_GRP0;
      cmd_cnt       <= 4'h0;
      msg_cnt       <= 2'h0;
      atn_sel       <= 1'b0;
      fifo_wr_out   <= 1'b0;
      fifo_data_out <= {DATA_W{1'b0}};
      phase_out     <= PH_NONE;
      busy_out      <= 1'b0;
    end else begin
      state         <= next_state;
      cause         <= next_cause;
      step          <= next_step;
      group         <= next_group;
      group_valid   <= next_group_valid;
      cmd_len       <= next_cmd_len;
      cmd_cnt       <= next_cmd_cnt;
      msg_cnt       <= next_msg_cnt;
      atn_sel       <= next_atn_sel;
      fifo_wr_out   <= next_fifo_wr;
      fifo_data_out <= next_fifo_data;
      phase_out     <= (next_state == ST_MSG) ? PH_MSG :
                       (next_state == ST_CMD || next_state == ST_NULL) ? PH_CMD : PH_NONE;
      busy_out      <= (next_state != ST_IDLE);
    end
  end

  // Software registers; the interrupt output lags the status bits by one clock
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl       <= `TSS_CTRL_RESET;
      irq_status <= 3'h0;
      irq_mask   <= `TSS_MASK_RESET;
      irq_out    <= 1'b0;
    end else begin
      if (wr_in && addr_in == `TSS_OFF_CTRL) begin
        ctrl <= wdata_in;
      end
      if (wr_in && addr_in == `TSS_OFF_IRQ_MASK) begin
        irq_mask <= wdata_in[2:0];
      end
      irq_status <= next_irq_status;
      irq_out    <= |(irq_status & irq_mask);
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `TSS_OFF_CTRL:       rdata_out <= ctrl;
        `TSS_OFF_IRQ_STATUS: rdata_out <= {5'h00, irq_status};
        `TSS_OFF_IRQ_MASK:   rdata_out <= {5'h00, irq_mask};
        `TSS_OFF_GROUP:      rdata_out <= {4'h0, group_valid, group};
        `TSS_OFF_CAUSE:      rdata_out <= cause;
        `TSS_OFF_STEP:       rdata_out <= {5'h00, step};
        default:             rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

endmodule

// file: sim/tb.sv
// Testbench for the target select sequencer: scenarios for every outcome code except step 6 with cause 12 hex.
// Assumes the initiator model drives the link inputs and the bench owns the register port.
`timescale 1ns/100ps
module tb;
  logic       clk_in, rst_n_in, wr_in, rd_in, irq_out, fifo_wr_out, busy_out;
  logic       sel_in, sel_atn_in, atn_pin_in, byte_valid_in, parity_err_in;
  logic [3:0] addr_in;
  logic [7:0] wdata_in, rdata_out, bus_id_in, byte_in, fifo_data_out, rv;
  logic [1:0] phase_out;
  logic [7:0] fq[$];
  int         fail_count = 0;
  int         checked = 0;

  tss_sequencer #(.DATA_W(8)) tss_sequencer_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .sel_in(sel_in),
    .sel_atn_in(sel_atn_in), .bus_id_in(bus_id_in), .atn_pin_in(atn_pin_in), .byte_valid_in(byte_valid_in),
    .byte_in(byte_in), .parity_err_in(parity_err_in), .fifo_wr_out(fifo_wr_out),
    .fifo_data_out(fifo_data_out), .phase_out(phase_out), .busy_out(busy_out), .irq_out(irq_out));
  tss_initiator_model tss_initiator_model_i (.clk_in(clk_in), .sel_out(sel_in), .sel_atn_out(sel_atn_in),
    .bus_id_out(bus_id_in), .atn_out(atn_pin_in), .valid_out(byte_valid_in), .byte_out(byte_in),
    .perr_out(parity_err_in));

  // 40 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Collect every push so the stored bytes can be compared
  always @(posedge clk_in) begin
    if (fifo_wr_out === 1'b1)
      fq.push_back(fifo_data_out);
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  task automatic end_sim();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Register port: one-cycle strobes, read data sampled in the following cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rc(input string nm, input logic [3:0] a, input logic [7:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 rv = rdata_out;
    chk(nm, e, rv);
    @(posedge clk_in);
  endtask
  task automatic ic(input logic e);
    @(posedge clk_in);
    #1 chk("irq", {7'h00, e}, {7'h00, irq_out});
  endtask

  // One selection: messages, then command bytes up to an optional parity error at index pe
  task automatic scen(input int e, sa, nm, input logic [7:0] m0, input int am, input logic [7:0] c0,
                      input int nc, pe, ac, input logic [2:0] st, input logic [7:0] ca);
    int n;
    int ok;
    fq.delete();
    ok = (pe < nc) ? pe : nc;
    wr(4'h0, {6'h00, 1'b1, e[0]});
    tss_initiator_model_i.set_atn(sa[0]);
    tss_initiator_model_i.select(sa[0], 8'h42);
    for (n = 0; n < nm; n++) begin
      // Drop valid before the settle wait, or the previous byte would repeat
      if (n == nm - 1) begin
        tss_initiator_model_i.idle();
        tss_initiator_model_i.set_atn(am[0]);
      end
      tss_initiator_model_i.send(n == 0 ? m0 : 8'h20 + n[7:0], n == 0 && pe == 0 && nc == 0);
    end
    if (nm > 0)
      tss_initiator_model_i.idle();
    if (nc > 0) begin
      tss_initiator_model_i.set_atn(ac[0]);
      for (n = 0; n < nc && n <= pe; n++)
        tss_initiator_model_i.send(n == 0 ? c0 : n[7:0], n == pe);
      tss_initiator_model_i.idle();
    end
    for (n = 0; n < 60 && irq_out !== 1'b1; n++)
      @(negedge clk_in);
    @(posedge clk_in);
    chk("irq wait", 8'h01, {7'h00, irq_out});
    if (irq_out !== 1'b1)
      end_sim();
    chk("busy hold", 8'h01, {7'h00, busy_out});
    chk("phase hold", 8'h00, {6'h00, phase_out});
    rc("step", 4'h6, {5'h00, st});
    rc("cause", 4'h5, ca);
    rc("step held", 4'h6, {5'h00, st});
    chk("busy idle", 8'h00, {7'h00, busy_out});
    if (nc > 0 && pe >= nc)
      rc("group", 4'h3, {4'h0, c0[7:5] inside {3'h0, 3'h1, 3'h2, 3'h5}, c0[7:5]});
    chk("pushes", 8'((sa ? 1 + nm : 2) + ok), 8'(fq.size()));
    chk("id", 8'h42, fq[0]);
    chk("second", sa ? m0 : 8'h00, fq[1]);
    for (n = 0; n < ok; n++)
      chk("cmd byte", n == 0 ? c0 : n[7:0], fq[fq.size() - ok + n]);
    rc("status set", 4'h1, {5'h00, am[0], pe == 0 || pe < nc || !m0[7], 1'b1});
    wr(4'h2, 8'h00);
    ic(1'b0);
    wr(4'h1, 8'h07);
    wr(4'h2, 8'h07);
    ic(1'b0);
    rc("status", 4'h1, 8'h00);
  endtask

  // Main sequence: reset values, then every outcome code except step 6, cause 12 hex
  initial begin
    {rst_n_in, wr_in, rd_in, addr_in, wdata_in} = '0;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    rc("cause rst", 4'h5, 8'h00);
    wr(4'h5, 8'hff);
    rc("cause ro", 4'h5, 8'h00);
    rc("step rst", 4'h6, 8'h00);
    rc("unmapped", 4'hf, 8'h00);
    rc("mask rst", 4'h2, 8'h00);
    wr(4'h2, 8'h07);
    scen(0, 0, 0, 8'h80, 0, 8'h00, 6, 99, 1, 3'h2, 8'h11);
    scen(0, 0, 0, 8'h80, 0, 8'h00, 6, 2, 1, 3'h1, 8'h11);
    scen(0, 0, 0, 8'h80, 0, 8'h20, 10, 99, 0, 3'h2, 8'h01);
    scen(0, 0, 0, 8'h80, 0, 8'h00, 6, 5, 0, 3'h1, 8'h01);
    scen(0, 1, 1, 8'h80, 0, 8'h40, 10, 99, 1, 3'h2, 8'h12);
    scen(0, 1, 1, 8'h80, 0, 8'h00, 6, 1, 1, 3'h1, 8'h12);
    scen(1, 1, 3, 8'h80, 0, 8'h00, 6, 0, 1, 3'h5, 8'h12);
    scen(0, 1, 1, 8'h80, 1, 8'h00, 0, 99, 0, 3'h0, 8'h12);
    scen(0, 1, 1, 8'h80, 0, 8'ha0, 12, 99, 0, 3'h2, 8'h02);
    scen(0, 1, 1, 8'h80, 0, 8'h00, 6, 4, 0, 3'h1, 8'h02);
    scen(0, 1, 1, 8'h01, 0, 8'h00, 0, 99, 0, 3'h0, 8'h02);
    scen(1, 1, 1, 8'h05, 0, 8'h00, 0, 99, 0, 3'h0, 8'h02);
    scen(1, 1, 1, 8'h80, 0, 8'h00, 0, 0, 0, 3'h0, 8'h02);
    scen(1, 1, 3, 8'h80, 1, 8'h00, 0, 99, 0, 3'h4, 8'h12);
    scen(1, 1, 3, 8'h80, 0, 8'h60, 6, 99, 0, 3'h6, 8'h02);
    scen(1, 1, 3, 8'h80, 0, 8'h20, 10, 9, 0, 3'h5, 8'h02);
    end_sim();
  end
endmodule

// file: sim/tss_initiator_model.sv
// Initiator model: selection, ATN level and received bytes toward the sequencer.
// Assumes each task is called just after a rising clk_in edge.
`timescale 1ns/100ps
module tss_initiator_model (
  input  logic       clk_in,
  output logic       sel_out,
  output logic       sel_atn_out,
  output logic [7:0] bus_id_out,
  output logic       atn_out,
  output logic       valid_out,
  output logic [7:0] byte_out,
  output logic       perr_out
);
  // Quiet bus at time zero
  initial begin
    {sel_out, sel_atn_out, bus_id_out, atn_out, valid_out, byte_out, perr_out} = '0;
  end
  // Released lines flip so a stale value is never mistaken for a live one
  task automatic select(input logic atn, input logic [7:0] id);
    sel_out <= 1'b1;
    sel_atn_out <= atn;
    bus_id_out <= id;
    @(posedge clk_in);
    sel_out <= 1'b0;
    sel_atn_out <= ~atn;
    bus_id_out <= ~id;
    @(posedge clk_in);
  endtask
  // ATN crosses a two-flop synchroniser, so it gets three cycles to settle
  task automatic set_atn(input logic v);
    atn_out <= v;
    repeat (3) @(posedge clk_in);
  endtask
  // Valid stays up across back-to-back bytes
  task automatic send(input logic [7:0] b, input logic pe);
    valid_out <= 1'b1;
    byte_out <= b;
    perr_out <= pe;
    @(posedge clk_in);
  endtask
  task automatic idle();
    valid_out <= 1'b0;
    byte_out <= ~byte_out;
    perr_out <= ~perr_out;
  endtask
endmodule

// file: sim/tss_sequencer_chk.sv
// Port checker for the target select sequencer: pushes, phases and register reads.
// Assumes it is bound into tss_sequencer and sees that module's ports only.
`timescale 1ns/100ps
module tss_sequencer_chk #(
  parameter DATA_W = 8
) (
  input logic              clk_in,
  input logic              rst_n_in,
  input logic [3:0]        addr_in,
  input logic [7:0]        wdata_in,
  input logic              wr_in,
  input logic              rd_in,
  input logic [7:0]        rdata_out,
  input logic              sel_in,
  input logic              sel_atn_in,
  input logic [DATA_W-1:0] bus_id_in,
  input logic              byte_valid_in,
  input logic [DATA_W-1:0] byte_in,
  input logic              parity_err_in,
  input logic              fifo_wr_out,
  input logic [DATA_W-1:0] fifo_data_out,
  input logic [1:0]        phase_out,
  input logic              busy_out
);
  logic en;
  logic take;
  // Shadow of the enable bit, since a selection is only taken once it is set
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      en <= 1'b0;
    else if (wr_in && addr_in == 4'h0)
      en <= wdata_in[1];
  end
  assign take = sel_in && en && !busy_out;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // Selection pushes the bus ID, then a null byte when ATN was false
  property p_sel_id; take |=> fifo_wr_out && fifo_data_out == $past(bus_id_in); endproperty
  a_sel_id: assert property (p_sel_id) else $error("bus ID not pushed");
  property p_null; take && !sel_atn_in |-> ##2 fifo_wr_out && fifo_data_out == 8'h00; endproperty
  a_null: assert property (p_null) else $error("null byte not pushed");
  property p_busy; take |=> busy_out [*2]; endproperty
  a_busy: assert property (p_busy) else $error("busy missing after selection");
  property p_phase; take |=> phase_out == ($past(sel_atn_in) ? 2'h1 : 2'h2); endproperty
  a_phase: assert property (p_phase) else $error("wrong phase after selection");
  // Good bytes are echoed one cycle later; the cycle after a selection without ATN ignores bytes
  property p_echo;
    byte_valid_in && !parity_err_in && phase_out != 2'h0 && !$past(sel_in)
      |=> fifo_wr_out && fifo_data_out == $past(byte_in);
  endproperty
  a_echo: assert property (p_echo) else $error("byte not echoed");
  property p_par; byte_valid_in && parity_err_in && phase_out == 2'h2 |=> !fifo_wr_out; endproperty
  a_par: assert property (p_par) else $error("bad command byte pushed");
  property p_idle; !busy_out && !sel_in |=> !fifo_wr_out; endproperty
  a_idle: assert property (p_idle) else $error("push while idle");
  // Read data stand one cycle only, step reads stay within three bits and cause codes inside their documented set
  property p_rd_idle; !rd_in |=> rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_step; rd_in && addr_in == 4'h6 |=> rdata_out[7:3] == 5'h00; endproperty
  a_step: assert property (p_step) else $error("step above three bits");
  property p_cause;
    rd_in && addr_in == 4'h5 |=> rdata_out inside {8'h00, 8'h01, 8'h02, 8'h11, 8'h12};
  endproperty
  a_cause: assert property (p_cause) else $error("unknown cause code");
  c_atn: cover property (take && sel_atn_in);
  c_par: cover property (byte_valid_in && parity_err_in);
  c_cause: cover property (rd_in && addr_in == 4'h5);
endmodule

bind tss_sequencer tss_sequencer_chk #(.DATA_W(DATA_W)) tss_sequencer_chk_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
  .rd_in(rd_in), .rdata_out(rdata_out), .sel_in(sel_in), .sel_atn_in(sel_atn_in), .bus_id_in(bus_id_in),
  .byte_valid_in(byte_valid_in), .byte_in(byte_in), .parity_err_in(parity_err_in),
  .fifo_wr_out(fifo_wr_out), .fifo_data_out(fifo_data_out), .phase_out(phase_out), .busy_out(busy_out));
